/* File: pkg/wwdc_pkg.sv */
// constants, field layout and carrier types of the windowed watchdog control block
`default_nettype none

package wwdc_pkg;

	// ************************************************************
	// register map (byte addresses, one aligned word each)
	// ************************************************************
	localparam logic [7:0] ADDR_CONTROL_ZERO = 8'h00;
	localparam logic [7:0] ADDR_CONTROL_ONE = 8'h04;
	localparam logic [7:0] ADDR_PRESCALE_LOW = 8'h08;
	localparam logic [7:0] ADDR_PRESCALE_HIGH = 8'h0C;
	localparam logic [7:0] ADDR_COUNTER_VIEW = 8'h10;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CTL0_ENABLE_BIT = 0;
	localparam int CTL0_PRESCALE_LSB = 1;
	localparam int CTL1_WINDOW_LSB = 0;
	localparam int CTL1_SOURCE_LSB = 4;
	localparam int VIEW_PS_HIGH_LSB = 0;
	localparam int VIEW_ARMED_BIT = 2;
	localparam int VIEW_COUNT_LSB = 3;

	// ************************************************************
	// field codes and reset values
	// ************************************************************
	localparam logic [4:0] PRESCALE_UNLOCK = 5'h1F;
	localparam logic [4:0] PRESCALE_RESET = 5'h0B;
	localparam logic [4:0] PRESCALE_LAST_CODE = 5'h12;
	localparam logic [4:0] PRESCALE_MIN_CODE = 5'h00;
	localparam logic [5:0] PRESCALE_BASE_SHIFT = 6'h05;
	localparam logic [2:0] SOURCE_UNLOCK = 3'h7;
	localparam logic [2:0] SOURCE_RESET = 3'h0;
	localparam logic [2:0] SOURCE_SLOW = 3'h0;
	localparam logic [2:0] SOURCE_MEDIUM = 3'h1;
	localparam logic [2:0] WINDOW_UNLOCK = 3'h7;
	localparam logic [2:0] WINDOW_FULL = 3'h7;
	localparam logic ENABLE_RESET = 1'b0;
	localparam logic [31:0] READ_ZERO = 32'h00000000;

	// ************************************************************
	// widths
	// ************************************************************
	localparam int PRESCALE_COUNT_W = 18;
	localparam int COUNT_VIEW_W = 4;

	// watchdog operating modes from the configuration word
	typedef enum logic [1:0] {
		WWDC_MODE_OFF = 2'h0,
		WWDC_MODE_SOFT = 2'h1,
		WWDC_MODE_AWAKE = 2'h2,
		WWDC_MODE_ON = 2'h3
	} wwdc_mode_t;

	// configuration word fields that steer the block
	typedef struct packed {
		wwdc_mode_t config_watchdog_mode;
		logic [4:0] config_prescale_field;
		logic [2:0] config_clock_source_field;
		logic [2:0] config_window_size_field;
	} wwdc_cfg_t;

	// watchdog events towards the reset and power logic
	typedef struct packed {
		logic watchdog_reset;
		logic window_violation_clear;
		logic sleep_wake;
	} wwdc_evt_t;

endpackage

`default_nettype wire

/* File: rtl/wwdc_core.sv */
// windowed watchdog timer: control registers, prescaler, window check and reset events
`timescale 1ns/10ps
`default_nettype none

module wwdc_core
	import wwdc_pkg::*;
#(
	parameter int unsigned ADDR_W = 8,
	parameter int unsigned COUNTER_W = 5,
	parameter int unsigned SYNC_STAGES = 3
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire wwdc_pkg::wwdc_cfg_t cfg,
	input wire logic slow_osc_clk,
	input wire logic medium_osc_clk,
	input wire logic clear_request,
	input wire logic sleep_mode,
	output wwdc_pkg::wwdc_evt_t events,
	output logic watchdog_running
);
	import wwdc_pkg::*;

	localparam int EL_W = PRESCALE_COUNT_W + COUNTER_W;

	// ************************************************************
	// elaboration checks
	// ************************************************************
	// the longest period is 2^23 ticks, so prescaler plus counter must hold it
	if (COUNTER_W != 5) begin : g_bad_counter
		$error("counter width must be 5 to reach the longest period");
	end
	if (ADDR_W < 8) begin : g_bad_addr
		$error("address width must reach the highest register");
	end
	if (SYNC_STAGES != 3) begin : g_bad_sync
		$error("oscillator input synchroniser must have three stages");
	end

	// ************************************************************
	// oscillator tick recovery
	// ************************************************************
	// the oscillators run outside clk, so each passes three flops and a
	// level change only counts once the second and third stages agree
	logic [1:0] osc_pin;
	logic [1:0] osc_level_reg;
	logic [1:0] osc_tick;

	assign osc_pin = {medium_osc_clk, slow_osc_clk};

	genvar gi;
	for (gi = 0; gi < 2; gi++) begin : g_osc
		logic [SYNC_STAGES-1:0] sync_reg;
		logic level_next;

		// stage one feeds stage two only
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				sync_reg <= '0;
			end else begin
				sync_reg <= {sync_reg[SYNC_STAGES-2:0], osc_pin[gi]};
			end
		end

		assign level_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : osc_level_reg[gi];

		// filtered level and rising-edge tick
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				osc_level_reg[gi] <= 1'b0;
			end else begin
				osc_level_reg[gi] <= level_next;
			end
		end

		assign osc_tick[gi] = level_next & ~osc_level_reg[gi];
	end

	// ************************************************************
	// apb decode
	// ************************************************************
	logic apb_setup;
	logic apb_access;
	logic wr_fire;
	logic rd_fire;
	logic [7:0] addr_byte;
	logic hit_ctl0;
	logic hit_ctl1;
	logic hit_psl;
	logic hit_psh;
	logic hit_view;
	logic addr_hit;

	assign apb_setup = psel & ~penable;
	assign apb_access = psel & penable;
	assign wr_fire = apb_access & pwrite;
	assign rd_fire = apb_access & ~pwrite;
	assign addr_byte = paddr[7:0];
	// upper address bits must be zero for any register to match
	assign addr_hit = (paddr >> 8) == '0;
	assign hit_ctl0 = addr_hit & (addr_byte == ADDR_CONTROL_ZERO);
	assign hit_ctl1 = addr_hit & (addr_byte == ADDR_CONTROL_ONE);
	assign hit_psl = addr_hit & (addr_byte == ADDR_PRESCALE_LOW);
	assign hit_psh = addr_hit & (addr_byte == ADDR_PRESCALE_HIGH);
	assign hit_view = addr_hit & (addr_byte == ADDR_COUNTER_VIEW);

	// ************************************************************
	// control fields
	// ************************************************************
	logic [4:0] prescale_select_reg;
	logic [4:0] prescale_select_next;
	logic software_enable_bit_reg;
	logic software_enable_bit_next;
	logic [2:0] clock_source_select_reg;
	logic [2:0] clock_source_select_next;
	logic [2:0] window_select_reg;
	logic [2:0] window_select_next;
	logic ps_unlocked;
	logic cs_unlocked;
	logic win_unlocked;
	logic ctl0_write;
	logic ctl1_write;
	logic [4:0] ps_reset_value;
	logic [2:0] cs_reset_value;

	assign ps_unlocked = cfg.config_prescale_field == PRESCALE_UNLOCK;
	assign cs_unlocked = cfg.config_clock_source_field == SOURCE_UNLOCK;
	assign win_unlocked = cfg.config_window_size_field == WINDOW_UNLOCK;
	assign ctl0_write = wr_fire & hit_ctl0;
	assign ctl1_write = wr_fire & hit_ctl1;

	// reset values follow the configuration word
	assign ps_reset_value = ps_unlocked ? PRESCALE_RESET : cfg.config_prescale_field;
	assign cs_reset_value = cs_unlocked ? SOURCE_RESET : cfg.config_clock_source_field;

	// locked fields ignore writes but the write still clears the counters
	assign prescale_select_next = (ctl0_write && ps_unlocked) ?
		pwdata[CTL0_PRESCALE_LSB +: 5] : prescale_select_reg;
	assign software_enable_bit_next = ctl0_write ?
		pwdata[CTL0_ENABLE_BIT] : software_enable_bit_reg;
	assign clock_source_select_next = (ctl1_write && cs_unlocked) ?
		pwdata[CTL1_SOURCE_LSB +: 3] : clock_source_select_reg;
	assign window_select_next = (ctl1_write && win_unlocked) ?
		pwdata[CTL1_WINDOW_LSB +: 3] : window_select_reg;

	// synchronous reset loads configuration-driven values; the enable bit loads zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prescale_select_reg <= ps_reset_value;
			software_enable_bit_reg <= ENABLE_RESET;
			clock_source_select_reg <= cs_reset_value;
			window_select_reg <= cfg.config_window_size_field;
		end else begin
			prescale_select_reg <= prescale_select_next;
			software_enable_bit_reg <= software_enable_bit_next;
			clock_source_select_reg <= clock_source_select_next;
			window_select_reg <= window_select_next;
		end
	end

	// ************************************************************
	// operating mode and time base
	// ************************************************************
	logic active;
	logic windowed;
	logic tick;
	logic sleep_reg;
	logic sleep_change;

	// mode 01 honours the enable bit; other modes ignore it
	always_comb begin
		case (cfg.config_watchdog_mode)
			WWDC_MODE_ON: active = 1'b1;
			WWDC_MODE_AWAKE: active = ~sleep_mode;
			WWDC_MODE_SOFT: active = software_enable_bit_reg;
			WWDC_MODE_OFF: active = 1'b0;
			default: active = 1'b0;
		endcase
	end

	// reserved source codes give no tick, so the watchdog stalls rather than guess
	assign tick = (clock_source_select_reg == SOURCE_SLOW) ? osc_tick[0] :
		(clock_source_select_reg == SOURCE_MEDIUM) ? osc_tick[1] : 1'b0;

	assign windowed = window_select_reg != WINDOW_FULL;
	assign sleep_change = sleep_mode ^ sleep_reg;

	// previous sleep level, to clear on entry and exit
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sleep_reg <= 1'b0;
		end else begin
			sleep_reg <= sleep_mode;
		end
	end

	// ************************************************************
	// period and window arithmetic
	// ************************************************************
	logic [4:0] ps_code_eff;
	logic [5:0] period_shift;
	logic [EL_W:0] period;
	logic [EL_W:0] last_count;
	logic [2:0] closed_eighths;
	logic [EL_W+3:0] closed_limit;
	logic [PRESCALE_COUNT_W-1:0] prescale_count_reg;
	logic [COUNTER_W-1:0] wdt_count_reg;
	logic [EL_W-1:0] elapsed;
	logic [EL_W-1:0] elapsed_next;
	logic in_window;
	logic timeout;

	// reserved codes fall back to the shortest period
	assign ps_code_eff = (prescale_select_reg > PRESCALE_LAST_CODE) ?
		PRESCALE_MIN_CODE : prescale_select_reg;
	// period is 2^(5+code) oscillator ticks
	assign period_shift = PRESCALE_BASE_SHIFT + {1'b0, ps_code_eff};
	assign period = (EL_W+1)'(1) << period_shift;
	assign last_count = period - (EL_W+1)'(1);
	assign elapsed = {wdt_count_reg, prescale_count_reg};
	assign elapsed_next = elapsed + EL_W'(1);

	// closed part of the period, in eighths; window code 111 has none
	assign closed_eighths = WINDOW_FULL - window_select_reg;
	assign closed_limit = (EL_W+4)'(period >> 3) * (EL_W+4)'(closed_eighths);
	assign in_window = (EL_W+4)'(elapsed) >= closed_limit;

	assign timeout = active & tick & ((EL_W+1)'(elapsed) == last_count);

	// ************************************************************
	// clear handling and arming
	// ************************************************************
	logic armed_reg;
	logic armed_next;
	logic arm_read;
	logic clear_seen;
	logic clear_valid;
	logic violation;
	logic counter_clear;

	assign arm_read = rd_fire & hit_ctl0;
	assign clear_seen = clear_request & active;
	// without a window the clear needs no arming
	assign clear_valid = clear_seen & (~windowed | (armed_reg & in_window));
	assign violation = clear_seen & windowed & ~(armed_reg & in_window);
	assign counter_clear = clear_valid | violation | ctl0_write | ctl1_write |
		sleep_change | ~active;

	// an arming read in the same cycle as a clear wins, as a set over a clear
	assign armed_next = arm_read ? 1'b1 : (clear_seen ? 1'b0 : armed_reg);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			armed_reg <= 1'b0;
		end else begin
			armed_reg <= armed_next;
		end
	end

	// ************************************************************
	// prescaler and watchdog counter
	// ************************************************************
	// both counters share one carry chain; a time-out wraps them to zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prescale_count_reg <= '0;
			wdt_count_reg <= '0;
		end else if (counter_clear || timeout) begin
			prescale_count_reg <= '0;
			wdt_count_reg <= '0;
		end else if (active && tick) begin
			prescale_count_reg <= elapsed_next[PRESCALE_COUNT_W-1:0];
			wdt_count_reg <= elapsed_next[EL_W-1:PRESCALE_COUNT_W];
		end
	end

	// ************************************************************
	// reset and wake events
	// ************************************************************
	wwdc_evt_t events_reg;
	wwdc_evt_t events_next;
	logic running_reg;

	// a time-out in sleep wakes the core instead of resetting it
	always_comb begin
		events_next.watchdog_reset = (timeout & ~sleep_mode) | violation;
		events_next.window_violation_clear = violation;
		events_next.sleep_wake = timeout & sleep_mode;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			events_reg <= '0;
			running_reg <= 1'b0;
		end else begin
			events_reg <= events_next;
			running_reg <= active;
		end
	end

	assign events = events_reg;
	assign watchdog_running = running_reg;

	// ************************************************************
	// read data
	// ************************************************************
	logic [31:0] rd_mux;
	logic [31:0] prdata_reg;
	logic err_reg;

	// unimplemented and upper bits stay zero
	always_comb begin
		rd_mux = READ_ZERO;
		if (hit_ctl0) begin
			rd_mux[CTL0_PRESCALE_LSB +: 5] = prescale_select_reg;
			rd_mux[CTL0_ENABLE_BIT] = software_enable_bit_reg;
		end else if (hit_ctl1) begin
			rd_mux[CTL1_SOURCE_LSB +: 3] = clock_source_select_reg;
			rd_mux[CTL1_WINDOW_LSB +: 3] = window_select_reg;
		end else if (hit_psl) begin
			rd_mux[7:0] = prescale_count_reg[7:0];
		end else if (hit_psh) begin
			rd_mux[7:0] = prescale_count_reg[15:8];
		end else if (hit_view) begin
			rd_mux[VIEW_COUNT_LSB +: COUNT_VIEW_W] = wdt_count_reg[COUNT_VIEW_W-1:0];
			rd_mux[VIEW_ARMED_BIT] = armed_reg;
			rd_mux[VIEW_PS_HIGH_LSB +: 2] = prescale_count_reg[17:16];
		end
	end

	// the read word is sampled in the setup cycle, so the access cycle
	// returns it from a flop; the cost is a one-cycle-old snapshot
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata_reg <= READ_ZERO;
			err_reg <= 1'b0;
		end else if (apb_setup) begin
			prdata_reg <= pwrite ? READ_ZERO : rd_mux;
			err_reg <= ~(hit_ctl0 | hit_ctl1 | hit_psl | hit_psh | hit_view);
		end
	end

	// zero wait states; writes to read-only registers are quietly ignored
	assign pready = 1'b1;
	assign prdata = prdata_reg;
	assign pslverr = apb_access & err_reg;

endmodule // wwdc_core

`default_nettype wire

/* File: tb/wwdc_core_assertions.sv */
// port checker of the windowed watchdog control block, bound to its top
`timescale 1ns/10ps
`default_nettype none

module wwdc_core_chk
	import wwdc_pkg::*;
#(
	parameter int unsigned ADDR_W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire wwdc_pkg::wwdc_cfg_t cfg,
	input wire wwdc_pkg::wwdc_evt_t events,
	input wire logic watchdog_running
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ********
	// access decode
	// ********
	// upper address bits must be zero for a hit, so compare the cast back
	wire logic rd_acc = psel && penable && !pwrite;
	wire logic [7:0] a8 = paddr[7:0];
	wire logic hit = (ADDR_W'(a8) == paddr) && (a8 inside {ADDR_CONTROL_ZERO,
		ADDR_CONTROL_ONE, ADDR_PRESCALE_LOW, ADDR_PRESCALE_HIGH, ADDR_COUNTER_VIEW});
	wire logic ctl0 = rd_acc && a8 == ADDR_CONTROL_ZERO;
	wire logic ctl1 = rd_acc && a8 == ADDR_CONTROL_ONE;

	// ********
	// properties
	// ********
	// reset must silence outputs, so this one ignores the default disable
	a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=>
		events == '0 && prdata == '0 && !watchdog_running) else $error("busy in reset");
	a_unmapped_err: assert property (psel && penable && !hit |-> pslverr && prdata == '0)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (psel && penable && hit |-> pready && !pslverr)
		else $error("mapped access refused");
	a_unused_zero: assert property (rd_acc |-> prdata[31:7] == '0 &&
		!(a8 == ADDR_CONTROL_ZERO && prdata[6]) && !(a8 == ADDR_CONTROL_ONE && prdata[3]))
		else $error("unimplemented bit reads one");
	a_ps_locked: assert property (ctl0 && cfg.config_prescale_field != 5'h1F |->
		prdata[5:1] == cfg.config_prescale_field) else $error("locked prescale moved");
	a_src_locked: assert property (ctl1 && cfg.config_clock_source_field != 3'h7 |->
		prdata[6:4] == cfg.config_clock_source_field) else $error("locked source moved");
	a_win_locked: assert property (ctl1 && cfg.config_window_size_field != 3'h7 |->
		prdata[2:0] == cfg.config_window_size_field) else $error("locked window moved");
	a_off_idle: assert property (cfg.config_watchdog_mode == WWDC_MODE_OFF |=>
		!watchdog_running) else $error("runs while off");
	a_on_runs: assert property (cfg.config_watchdog_mode == WWDC_MODE_ON && $past(rst_n)
		|=> watchdog_running) else $error("idle while always on");
	a_event_pulse: assert property (events.watchdog_reset |=> !events.watchdog_reset)
		else $error("reset event longer than one cycle");
	a_flag_with_rst: assert property (events.window_violation_clear |->
		events.watchdog_reset) else $error("violation without reset");

	// main scenarios reached
	c_timeout: cover property (events.watchdog_reset && !events.window_violation_clear);
	c_violation: cover property (events.window_violation_clear);
	c_refused: cover property (pslverr);
endmodule // wwdc_core_chk

bind wwdc_core wwdc_core_chk #(.ADDR_W(ADDR_W)) u_wwdc_core_chk (.clk(clk), .rst_n(rst_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg(cfg), .events(events),
	.watchdog_running(watchdog_running));

`default_nettype wire

/* File: tb/wwdc_core_tb.sv */
// self-checking bench of the windowed watchdog control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module wwdc_core_tb;
	import wwdc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clear_request = 1'b0, sleep_mode = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000, prdata, rd, d;
	logic pready, pslverr, watchdog_running, err, saw_rst, saw_flag;
	wwdc_cfg_t cfg = '0;
	wwdc_evt_t events;
	logic osc = 1'b0, osc_div = 1'b0, slow_en = 1'b0, med_en = 1'b0;
	int ticks = 0, errors = 0, n_compared = 0;
	logic [4:0] codes [5] = '{5'h00, 5'h01, 5'h02, 5'h13, 5'h1F};
	wire logic slow_osc_clk = osc & slow_en;
	wire logic medium_osc_clk = osc & med_en;

	always #12.5 clk = ~clk;

	// oscillator stand-in: a tick every four clocks keeps periods short
	always @(posedge clk) begin
		osc_div <= ~osc_div;
		if (osc_div) begin
			osc <= ~osc;
			ticks <= ticks + (osc ? 0 : 1);
		end
	end

	wwdc_core u_wwdc_core (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cfg(cfg), .slow_osc_clk(slow_osc_clk),
		.medium_osc_clk(medium_osc_clk), .clear_request(clear_request),
		.sleep_mode(sleep_mode), .events(events), .watchdog_running(watchdog_running));

	// ********
	// expectations and drivers
	// ********
	function automatic logic [4:0] ps_reset(input logic [4:0] c);
		return (c == 5'h1F) ? 5'h0B : c;
	endfunction

	// reserved codes fall back to the shortest period
	function automatic int exp_period(input logic [4:0] c);
		return (c > 5'h12) ? 32 : 32 << c;
	endfunction

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// one transfer; an idle cycle follows so psel is never set twice at one edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v,
		output logic [31:0] r, output logic e);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			errors++;
			finish_test();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		apb(1'b1, a, v, rd, err);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		apb(1'b0, a, 32'h00000000, rd, err);
		`CHK(rd, {24'h000000, e})
	endtask

	task automatic wait_ticks(input int n);
		int t0;
		t0 = ticks;
		for (int k = 0; k < 8 * n + 16 && ticks - t0 < n; k++) @(posedge clk);
		// a stalled time base is a bench fault, not something to wait out
		if (ticks - t0 < n) begin
			errors++;
			finish_test();
		end
	endtask

	// ticks from the restarting write to the reset event, two ticks of slack each way
	task automatic time_out(input int p);
		int t0;
		t0 = ticks;
		for (int k = 0; k < 4 * p + 64 && events.watchdog_reset !== 1'b1; k++) @(posedge clk);
		// no event within the bound counts as a mismatch and ends the run
		if (events.watchdog_reset !== 1'b1) begin
			errors++;
			finish_test();
		end
		`CHK((ticks - t0 >= p - 2) && (ticks - t0 <= p + 2), 1'b1)
	endtask

	task automatic clr();
		clear_request <= 1'b1;
		@(posedge clk);
		clear_request <= 1'b0;
		saw_rst = 1'b0;
		saw_flag = 1'b0;
		repeat (4) begin
			@(posedge clk);
			saw_rst |= events.watchdog_reset;
			saw_flag |= events.window_violation_clear;
		end
	endtask

	task automatic do_reset(input wwdc_cfg_t c);
		rst_n <= 1'b0;
		cfg <= c;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask

	// ********
	// scenarios
	// ********
	initial begin
		void'($urandom(32'h5061));
		do_reset({WWDC_MODE_ON, 5'h1F, 3'h7, 3'h7});
		rd_chk(ADDR_CONTROL_ZERO, {2'h0, ps_reset(5'h1F), 1'b0});
		rd_chk(ADDR_CONTROL_ONE, 8'h07);
		// the control read above has armed the watchdog, so bit 2 is set
		rd_chk(ADDR_COUNTER_VIEW, 8'h04);
		wr(ADDR_PRESCALE_HIGH, 32'hFFFFFFFF);
		rd_chk(ADDR_PRESCALE_HIGH, 8'h00);
		apb(1'b0, 8'h14, 32'h00000000, rd, err);
		`CHK({err, rd}, 33'h100000000)
		// unlocked fields take random values, gaps stay zero
		for (int i = 0; i < 8; i++) begin
			d = $urandom;
			wr(ADDR_CONTROL_ZERO, d);
			rd_chk(ADDR_CONTROL_ZERO, {2'h0, d[5:0]});
			wr(ADDR_CONTROL_ONE, d);
			rd_chk(ADDR_CONTROL_ONE, {1'h0, d[6:4], 1'h0, d[2:0]});
		end
		slow_en <= 1'b1;
		wr(ADDR_CONTROL_ONE, 32'h00000007);
		foreach (codes[i]) begin
			wr(ADDR_CONTROL_ZERO, {26'h0, codes[i], 1'b0});
			time_out(exp_period(codes[i]));
		end
		// stop the time base so the count holds still, then a write must zero it
		wait_ticks(10);
		slow_en <= 1'b0;
		repeat (12) @(posedge clk);
		apb(1'b0, ADDR_PRESCALE_LOW, 32'h00000000, rd, err);
		`CHK(rd[7:0] != 8'h00, 1'b1)
		wr(ADDR_CONTROL_ONE, 32'h00000007);
		rd_chk(ADDR_PRESCALE_LOW, 8'h00);
		apb(1'b0, ADDR_COUNTER_VIEW, 32'h00000000, rd, err);
		`CHK(rd & 32'hFFFFFFFB, 32'h00000000)
		med_en <= 1'b1;
		wr(ADDR_CONTROL_ONE, 32'h00000017);
		wr(ADDR_CONTROL_ZERO, 32'h00000000);
		time_out(32);
		// reserved source has no time base: nothing may fire
		slow_en <= 1'b1;
		wr(ADDR_CONTROL_ONE, 32'h00000027);
		saw_rst = 1'b0;
		repeat (300) begin
			@(posedge clk);
			saw_rst |= events.watchdog_reset;
		end
		`CHK(saw_rst, 1'b0)
		med_en <= 1'b0;
		wr(ADDR_CONTROL_ONE, 32'h00000003);
		rd_chk(ADDR_CONTROL_ZERO, 8'h00);
		apb(1'b0, ADDR_COUNTER_VIEW, 32'h00000000, rd, err);
		`CHK(rd[2], 1'b1)
		wait_ticks(2);
		clr();
		`CHK({saw_rst, saw_flag}, 2'b11)
		apb(1'b0, ADDR_COUNTER_VIEW, 32'h00000000, rd, err);
		`CHK(rd[2], 1'b0)
		wait_ticks(20);
		clr();
		`CHK({saw_rst, saw_flag}, 2'b11)
		rd_chk(ADDR_CONTROL_ZERO, 8'h00);
		wait_ticks(20);
		clr();
		`CHK({saw_rst, saw_flag}, 2'b00)
		do_reset({WWDC_MODE_SOFT, 5'h05, 3'h1, 3'h2});
		rd_chk(ADDR_CONTROL_ZERO, {2'h0, ps_reset(5'h05), 1'b0});
		rd_chk(ADDR_CONTROL_ONE, 8'h12);
		`CHK(watchdog_running, 1'b0)
		wr(ADDR_CONTROL_ZERO, 32'hFFFFFFFF);
		rd_chk(ADDR_CONTROL_ZERO, 8'h0B);
		`CHK(watchdog_running, 1'b1)
		wr(ADDR_CONTROL_ONE, 32'hFFFFFFFF);
		rd_chk(ADDR_CONTROL_ONE, 8'h12);
		do_reset({WWDC_MODE_OFF, 5'h1F, 3'h7, 3'h7});
		wr(ADDR_CONTROL_ZERO, 32'h00000001);
		`CHK(watchdog_running, 1'b0)
		do_reset({WWDC_MODE_AWAKE, 5'h1F, 3'h7, 3'h7});
		// the running flag is a flop, so let one more edge pass after release
		@(posedge clk);
		`CHK(watchdog_running, 1'b1)
		// awake-only mode stops once the core sleeps
		sleep_mode <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK(watchdog_running, 1'b0)
		finish_test();
	end

	// hang guard
	initial begin
		repeat (100000) @(posedge clk);
		errors++;
		finish_test();
	end
endmodule // wwdc_core_tb

`default_nettype wire
